/* File: ccr_chroma_regs.sv */
/*
 Chroma control register bank with its AXI4-Lite slave.
 Assumes mclk is the line-locked clock and all inputs are synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module ccr_chroma_regs (
  input wire logic mclk, // Clock, 125 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic [ccr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ccr_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic stdSearchStart, // Pulse: begin standard search
  input wire logic stdMatch, // Pulse: candidate recognised
  input wire logic stdMiss, // Pulse: candidate rejected
  input wire logic [6:0] agcGainCode, // Gain code from AGC loop
  input wire logic [7:0] blueDiffIn, // B-Y sample
  input wire logic [7:0] redDiffIn, // R-Y sample
  input wire logic [7:0] lumaIn, // Luma sample
  input wire logic colourDetected, // Burst present
  input wire logic statusSrcA, // Signal selected for output A
  input wire logic statusSrcB, // Signal selected for output B
  input wire logic horizontalSyncIn, // Undelayed hsync
  output logic autoDetectOn, // Auto standard detection active
  output logic filterPresetOn, // Filters follow detected standard
  output logic sharpPresetOn, // Sharpness follows detected standard
  output logic stdSearching, // Search in progress
  output logic [2:0] stdCandidate, // Standard under test
  output logic stdValid, // Standard recognised
  output logic [2:0] stdDetected, // Recognised standard
  output logic combEnable, // Adaptive chroma comb on
  output logic gainManual, // Programmed gain in use
  output logic [11:0] chromaGainQ, // Gain in 1/256 units
  output logic [9:0] blueDiffOut, // B-Y with two fraction bits
  output logic [9:0] redDiffOut, // R-Y with two fraction bits
  output logic chromaWide, // Effective chroma bandwidth wide
  output logic [2:0] lumaChromaBw, // Effective combined bandwidth
  output logic colourOn, // Colour output enabled
  output logic status_out_a, // Real-time status A
  output logic status_out_b, // Real-time status B
  output logic horizontal_sync_pulse, // Delayed hsync
  output logic [7:0] lumaOut // Delay-compensated luma
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [7:0] chroma_control_one;
    logic [7:0] chroma_gain_control;
    logic [7:0] chroma_control_two;
    logic [7:0] mode_delay_control;
    logic [7:0] detect_control;
    logic awHeld;
    logic [7:0] awIdx;
    logic wHeld;
    logic [7:0] wByte;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rByte;
    logic [1:0] rResp;
    ccr_srch_type srch;
    logic [2:0] cand;
    logic [2:0] det;
    logic detOk;
    logic [11:0] gainQ;
    logic [9:0] blueOut;
    logic [9:0] redOut;
    logic colour;
    logic outA;
    logic outB;
  } ccr_state_type;

  ccr_state_type st_ff, nxt_st;

  function automatic logic [7:0] addr_idx(input logic [AXI_ADDR_W-1:0] a);
    addr_idx = 8'(a[AXI_ADDR_W-1:2]);
  endfunction

  function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] a);
    logic [7:0] i;
    i = addr_idx(a);
    is_mapped = (a[1:0] == 2'h0) &&
                (i == IDX_CHROMA_ONE || i == IDX_GAIN || i == IDX_CHROMA_TWO ||
                 i == IDX_MODE_DELAY || i == IDX_DETECT);
  endfunction

  // Piecewise linear: 0 -> 0.5, 36 -> 1.125, 127 -> 7.5
  function automatic logic [11:0] gain_q(input logic [6:0] code);
    int c;
    int q;
    c = int'(code);
    if (c <= GAIN_CODE_NOM) begin
      q = GAIN_Q_MIN + (c * (GAIN_Q_NOM - GAIN_Q_MIN)) / GAIN_CODE_NOM;
    end else begin
      q = GAIN_Q_NOM + ((c - GAIN_CODE_NOM) * (GAIN_Q_MAX - GAIN_Q_NOM)) /
          (GAIN_CODE_MAX - GAIN_CODE_NOM);
    end
    gain_q = 12'(q);
  endfunction

  // Search list order after the preferred entry
  function automatic logic [2:0] next_std(input logic [2:0] s);
    case (s)
      STD_PAL_NTSC: next_std = STD_PAL_NTSCJ;
      STD_PAL_NTSCJ: next_std = STD_SECAM_NTSC;
      default: next_std = STD_PAL_NTSC;
    endcase
  endfunction

  logic [1:0] detMode;
  logic [2:0] prefStd;
  logic autoOn;
  logic presetFilt;
  logic doWrite;
  logic [7:0] wrIdx;
  logic [TAP_W-1:0] hsyncTap;
  logic [TAP_W-1:0] lumaTap;

  assign detMode = {st_ff.detect_control[B_AUTO_HI], st_ff.chroma_control_one[B_AUTO_LO]};
  assign prefStd = st_ff.chroma_control_one[B_PREF_LSB +: 3];
  assign autoOn = detMode != DET_OFF;
  assign presetFilt = st_ff.detOk &&
                      (detMode == DET_PRESET_ALL || detMode == DET_PRESET_FILT);

  assign s_axi_awready = !st_ff.awHeld && !st_ff.bValid;
  assign s_axi_wready = !st_ff.wHeld && !st_ff.bValid;
  assign s_axi_arready = !st_ff.rValid;
  assign doWrite = st_ff.awHeld && st_ff.wHeld && !st_ff.bValid;
  assign wrIdx = st_ff.awIdx;

  always_comb begin
    nxt_st = st_ff;

    // Write channel capture in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awIdx = is_mapped(s_axi_awaddr) ? addr_idx(s_axi_awaddr) : 8'hFF;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wByte = s_axi_wdata[7:0];
      nxt_st.wLane0 = s_axi_wstrb[0];
    end

    // New values act from the next clock, no commit step
    if (doWrite) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
      nxt_st.bValid = 1'b1;
      nxt_st.bResp = RESP_OKAY;
      if (st_ff.wLane0) begin
        case (wrIdx)
          IDX_CHROMA_ONE: nxt_st.chroma_control_one = st_ff.wByte;
          IDX_GAIN: nxt_st.chroma_gain_control = st_ff.wByte;
          IDX_CHROMA_TWO: nxt_st.chroma_control_two = st_ff.wByte;
          IDX_MODE_DELAY: nxt_st.mode_delay_control = st_ff.wByte;
          IDX_DETECT: nxt_st.detect_control = st_ff.wByte & (8'h01 << B_AUTO_HI);
          default: nxt_st.bResp = RESP_SLVERR;
        endcase
      end else if (wrIdx == 8'hFF) begin
        nxt_st.bResp = RESP_SLVERR;
      end
    end else if (st_ff.bValid && s_axi_bready) begin
      nxt_st.bValid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rValid = 1'b1;
      nxt_st.rResp = RESP_OKAY;
      nxt_st.rByte = 8'h00;
      if (!is_mapped(s_axi_araddr)) begin
        nxt_st.rResp = RESP_SLVERR;
      end else begin
        case (addr_idx(s_axi_araddr))
          IDX_CHROMA_ONE: nxt_st.rByte = st_ff.chroma_control_one;
          IDX_GAIN: nxt_st.rByte = st_ff.chroma_gain_control;
          IDX_CHROMA_TWO: nxt_st.rByte = st_ff.chroma_control_two;
          IDX_MODE_DELAY: nxt_st.rByte = st_ff.mode_delay_control;
          default: nxt_st.rByte = st_ff.detect_control;
        endcase
      end
    end else if (st_ff.rValid && s_axi_rready) begin
      nxt_st.rValid = 1'b0;
    end

    // Standard search, preferred entry tried first
    case (st_ff.srch)
      SRCH_IDLE: begin
        if (autoOn && stdSearchStart) begin
          nxt_st.srch = SRCH_PREF;
          nxt_st.cand = prefStd;
          nxt_st.detOk = 1'b0;
        end
      end
      SRCH_PREF, SRCH_NEXT: begin
        if (stdMatch) begin
          nxt_st.srch = SRCH_IDLE;
          nxt_st.det = st_ff.cand;
          nxt_st.detOk = 1'b1;
        end else if (stdMiss) begin
          nxt_st.srch = SRCH_NEXT;
          nxt_st.cand = next_std(st_ff.cand);
        end
      end
      default: begin
        nxt_st.srch = SRCH_IDLE;
      end
    endcase
    if (!autoOn) begin
      nxt_st.srch = SRCH_IDLE;
      nxt_st.detOk = 1'b0;
    end

    // Gain source select
    if (st_ff.chroma_gain_control[B_GAIN_MANUAL]) begin
      nxt_st.gainQ = gain_q(st_ff.chroma_gain_control[6:0]);
    end else begin
      nxt_st.gainQ = gain_q(agcGainCode);
    end

    // Fine colour-difference offsets in quarter LSBs
    nxt_st.blueOut = {blueDiffIn, 2'b00} |
                     10'(st_ff.chroma_control_two[B_BLUE_OFS_LSB +: 2]);
    nxt_st.redOut = {redDiffIn, 2'b00} |
                    10'(st_ff.chroma_control_two[B_RED_OFS_LSB +: 2]);

    nxt_st.colour = st_ff.mode_delay_control[B_KILLER_OVR] | colourDetected;
    nxt_st.outA = statusSrcA ^ st_ff.mode_delay_control[B_INV_A];
    nxt_st.outB = statusSrcB ^ st_ff.mode_delay_control[B_INV_B];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.chroma_control_one <= RST_CHROMA_ONE;
      st_ff.chroma_gain_control <= RST_GAIN;
      st_ff.chroma_control_two <= RST_CHROMA_TWO;
      st_ff.mode_delay_control <= RST_MODE_DELAY;
      st_ff.detect_control <= RST_DETECT;
      st_ff.srch <= SRCH_IDLE;
      st_ff.gainQ <= 12'(GAIN_Q_NOM);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Effective bandwidth: preset by standard or as programmed
  always_comb begin
    chromaWide = st_ff.chroma_control_two[B_CHROMA_BW];
    lumaChromaBw = st_ff.chroma_control_two[B_LCBW_LSB +: 3];
    if (presetFilt) begin
      case (st_ff.det)
        STD_PAL_NTSCJ: begin
          chromaWide = PRESET_WIDE_NTSCJ;
          lumaChromaBw = PRESET_LCBW_NTSCJ;
        end
        STD_SECAM_NTSC: begin
          chromaWide = PRESET_WIDE_SECAM;
          lumaChromaBw = PRESET_LCBW_SECAM;
        end
        default: begin
          chromaWide = PRESET_WIDE_PAL;
          lumaChromaBw = PRESET_LCBW_PAL;
        end
      endcase
    end
  end

  // Two-clock steps; luma sits at a base so negative codes fit
  assign hsyncTap = TAP_W'(int'(st_ff.mode_delay_control[B_HDEL_LSB +: 2]) *
                           LLC_STEP_CYCLES);
  assign lumaTap = TAP_W'((LUMA_BASE_STEPS +
                   int'($signed(st_ff.mode_delay_control[B_YDEL_LSB +: 3]))) *
                   LLC_STEP_CYCLES);

  ccr_delay_line #(.WIDTH(1), .DEPTH(DELAY_DEPTH)) hsyncDelay (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(horizontalSyncIn),
    .tap(hsyncTap),
    .dout(horizontal_sync_pulse)
  );

  ccr_delay_line #(.WIDTH(8), .DEPTH(DELAY_DEPTH)) lumaDelay (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(lumaIn),
    .tap(lumaTap),
    .dout(lumaOut)
  );

  assign s_axi_bvalid = st_ff.bValid;
  assign s_axi_bresp = st_ff.bResp;
  assign s_axi_rvalid = st_ff.rValid;
  assign s_axi_rresp = st_ff.rResp;
  assign s_axi_rdata = {24'h000000, st_ff.rByte};
  assign autoDetectOn = autoOn;
  assign filterPresetOn = presetFilt;
  assign sharpPresetOn = st_ff.detOk && detMode == DET_PRESET_ALL;
  assign stdSearching = st_ff.srch != SRCH_IDLE;
  assign stdCandidate = st_ff.cand;
  assign stdValid = st_ff.detOk;
  assign stdDetected = st_ff.det;
  assign combEnable = st_ff.chroma_control_one[B_COMB_EN];
  assign gainManual = st_ff.chroma_gain_control[B_GAIN_MANUAL];
  assign chromaGainQ = st_ff.gainQ;
  assign blueDiffOut = st_ff.blueOut;
  assign redDiffOut = st_ff.redOut;
  assign colourOn = st_ff.colour;
  assign status_out_a = st_ff.outA;
  assign status_out_b = st_ff.outB;
endmodule
`default_nettype wire

/* File: ccr_pkg.sv */
/*
 Chroma control register slice: shared constants and types.
 Assumes mclk acts as the line-locked clock and a 32-bit AXI4-Lite host.
*/
// Overview of operation
// - Detect 00 off, 01 presets filters and sharpness
// - Detect 10 presets filters, 11 no presets
// - Search always tries preferred standard first
// - Gain bit 7: 0 automatic, 1 programmed
// - Gain codes 0, 36, 127 give 0.5, 1.125, 7.5
// - Blue offset adds code quarter LSBs
// - Red offset adds code quarter LSBs
// - Bit 3: small or wide chroma bandwidth
// - Bandwidth field steps chroma up, luma down
// - Mode bit 7 forces colour on
// - Mode bit 6 inverts status output B
// - Hsync delayed 0..3 steps of two clocks
// - Mode bit 3 inverts status output A
// - Signed luma delay -4..+3, two-clock steps
// - Auto mode when either detect bit set
// - Inversion applies to any selected signal
`default_nettype none
package ccr_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CHROMA_ONE = 8'h0E;
  localparam logic [7:0] IDX_GAIN = 8'h0F;
  localparam logic [7:0] IDX_CHROMA_TWO = 8'h10;
  localparam logic [7:0] IDX_MODE_DELAY = 8'h11;
  localparam logic [7:0] IDX_DETECT = 8'h14;
  // Reset values
  localparam logic [7:0] RST_CHROMA_ONE = 8'h02;
  localparam logic [7:0] RST_GAIN = 8'h24;
  localparam logic [7:0] RST_CHROMA_TWO = 8'h00;
  localparam logic [7:0] RST_MODE_DELAY = 8'h00;
  localparam logic [7:0] RST_DETECT = 8'h00;
  // Field positions
  localparam int B_COMB_EN = 0;
  localparam int B_AUTO_LO = 1;
  localparam int B_PREF_LSB = 4;
  localparam int B_AUTO_HI = 2;
  localparam int B_GAIN_MANUAL = 7;
  localparam int B_BLUE_OFS_LSB = 6;
  localparam int B_RED_OFS_LSB = 4;
  localparam int B_CHROMA_BW = 3;
  localparam int B_LCBW_LSB = 0;
  localparam int B_KILLER_OVR = 7;
  localparam int B_INV_B = 6;
  localparam int B_HDEL_LSB = 4;
  localparam int B_INV_A = 3;
  localparam int B_YDEL_LSB = 0;
  // Detection control codes
  localparam logic [1:0] DET_OFF = 2'h0;
  localparam logic [1:0] DET_PRESET_ALL = 2'h1;
  localparam logic [1:0] DET_PRESET_FILT = 2'h2;
  // Preferred standard codes in the search list
  localparam logic [2:0] STD_PAL_NTSC = 3'h0;
  localparam logic [2:0] STD_PAL_NTSCJ = 3'h4;
  localparam logic [2:0] STD_SECAM_NTSC = 3'h5;
  // Filter presets per detected standard
  localparam logic [2:0] PRESET_LCBW_PAL = 3'h2;
  localparam logic [2:0] PRESET_LCBW_NTSCJ = 3'h3;
  localparam logic [2:0] PRESET_LCBW_SECAM = 3'h1;
  localparam logic PRESET_WIDE_PAL = 1'b1;
  localparam logic PRESET_WIDE_NTSCJ = 1'b1;
  localparam logic PRESET_WIDE_SECAM = 1'b0;
  // Gain curve, output in units of 1/256
  localparam int GAIN_CODE_NOM = 36;
  localparam int GAIN_CODE_MAX = 127;
  localparam int GAIN_Q_MIN = 128;
  localparam int GAIN_Q_NOM = 288;
  localparam int GAIN_Q_MAX = 1920;
  // Timing in line-locked clock periods
  localparam int LLC_STEP_CYCLES = 2;
  localparam int LUMA_BASE_STEPS = 4;
  localparam int DELAY_DEPTH = 16;
  localparam int TAP_W = 4;

  typedef enum logic [2:0] {
    SRCH_IDLE = 3'b001,
    SRCH_PREF = 3'b010,
    SRCH_NEXT = 3'b100
  } ccr_srch_type;
endpackage
`default_nettype wire

/* File: ccr_delay_line.sv */
/*
 Variable tap delay line.
 Output is tap+1 clocks behind the input; tap below DEPTH.
*/
`timescale 1ns/1ns
`default_nettype none
module ccr_delay_line #(
  parameter int WIDTH = 1,
  parameter int DEPTH = ccr_pkg::DELAY_DEPTH
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] din, // Sample in
  input wire logic [ccr_pkg::TAP_W-1:0] tap, // Extra delay in clocks
  output logic [WIDTH-1:0] dout // Delayed sample
);
  import ccr_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] sr;
    logic [WIDTH-1:0] out;
  } ccr_dl_type;

  ccr_dl_type st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sr = {st_ff.sr[DEPTH-2:0], din};
    if (tap == '0) begin
      nxt_st.out = din;
    end else begin
      nxt_st.out = st_ff.sr[tap - 1'b1];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.out;
endmodule
`default_nettype wire

/* File: ccr_chroma_regs_sva.sv */
/*
 Checker for the chroma control register bank.
 Bound to ccr_chroma_regs; sees only its ports, one clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module ccr_chroma_regs_sva (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic stdSearchStart, // Search start
  input wire logic stdSearching, // Search busy
  input wire logic stdValid, // Standard found
  input wire logic autoDetectOn, // Auto mode
  input wire logic filterPresetOn, // Filter presets
  input wire logic sharpPresetOn, // Sharpness presets
  input wire logic colourDetected, // Burst present
  input wire logic colourOn, // Colour enabled
  input wire logic statusSrcA, // Status source A
  input wire logic status_out_a, // Status output A
  input wire logic [11:0] chromaGainQ // Gain
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("No write response");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("Write taken during response");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("No read response");
  a_status_follow: assert property (
    $past(rst_n) && $past(rst_n, 2) && !$past(s_axi_bvalid) &&
    $past(statusSrcA) != $past(statusSrcA, 2)
    |-> status_out_a != $past(status_out_a))
    else $error("Status A does not follow source");
  a_colour_auto: assert property (
    $past(rst_n) && $past(colourDetected) |-> colourOn)
    else $error("Colour off with burst present");
  a_gain_span: assert property (
    chromaGainQ >= 12'h080 && chromaGainQ <= 12'h780)
    else $error("Gain outside range");
  a_sharp_preset: assert property (
    sharpPresetOn |-> filterPresetOn && autoDetectOn)
    else $error("Sharpness preset out of mode");
  a_filter_preset: assert property (
    filterPresetOn |-> stdValid && autoDetectOn)
    else $error("Filter preset without standard");
  a_search_go: assert property (
    stdSearchStart && autoDetectOn && !stdSearching |=> stdSearching)
    else $error("Search did not start");
  c_write: cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
  c_search: cover property (stdSearchStart && autoDetectOn);
  c_sharp: cover property (sharpPresetOn);
endmodule
bind ccr_chroma_regs ccr_chroma_regs_sva ccr_chroma_regs_sva_i (.*);
`default_nettype wire

/* File: ccr_chroma_regs_tb_top.sv */
/*
 Self-checking bench for the chroma control register bank.
 Drives every port itself; AXI4-Lite master tasks on mclk at 125 MHz.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin failCount++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module ccr_chroma_regs_tb_top;
  import ccr_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic stdSearchStart = 0, stdMatch = 0, stdMiss = 0, colourDetected = 0;
  logic statusSrcA = 0, statusSrcB = 0, horizontalSyncIn = 0;
  logic [6:0] agcGainCode = 7'h00;
  logic [7:0] blueDiffIn = 8'h5A, redDiffIn = 8'hA5, lumaIn = 8'h00, lumaOut;
  logic autoDetectOn, filterPresetOn, sharpPresetOn, stdSearching, stdValid, combEnable;
  logic gainManual, chromaWide, colourOn, status_out_a, status_out_b, horizontal_sync_pulse;
  logic [2:0] stdCandidate, stdDetected, lumaChromaBw;
  logic [11:0] chromaGainQ;
  logic [9:0] blueDiffOut, redDiffOut;
  int failCount = 0, samplesChecked = 0, i, k;
  logic pre;
  logic [7:0] idxs [5] = '{IDX_CHROMA_ONE, IDX_GAIN, IDX_CHROMA_TWO, IDX_MODE_DELAY, IDX_DETECT};
  logic [7:0] rsts [5] = '{RST_CHROMA_ONE, RST_GAIN, RST_CHROMA_TWO, RST_MODE_DELAY, RST_DETECT};
  logic [7:0] gc [3] = '{8'h00, 8'h24, 8'h7F};
  logic [11:0] gq [3] = '{12'h080, 12'h120, 12'h780};

  ccr_chroma_regs ccr_chroma_regs_i (.*);

  always #4 mclk = ~mclk;

  task automatic giveVerdict;
    $display("Checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 50) begin
      failCount++;
      $display("Error at %0t: handshake timeout", $time);
      giveVerdict();
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
    tmo(n);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
    tmo(n);
  endtask

  // Register write by index, upper bytes set to show they are ignored
  task automatic wr(input logic [7:0] x, input logic [7:0] d);
    axw({x[5:0], 2'b00}, {24'hFFFFFF, d}, RESP_OKAY);
    step(2);
  endtask

  task automatic pulse(input int p);
    @(posedge mclk);
    case (p)
      0: stdSearchStart <= 1'b1;
      1: stdMatch <= 1'b1;
      2: stdMiss <= 1'b1;
      3: horizontalSyncIn <= 1'b1;
      default: lumaIn <= 8'hC3;
    endcase
    @(posedge mclk);
    {stdSearchStart, stdMatch, stdMiss, horizontalSyncIn} <= 4'h0;
    lumaIn <= 8'h00;
  endtask

  // Clocks from input pulse to output
  task automatic meas(input int p, input int ex);
    int d;
    pulse(p);
    for (d = 1; d < 40; d++) begin
      #1;
      if (p == 3 ? horizontal_sync_pulse === 1'b1 : lumaOut === 8'hC3) break;
      @(posedge mclk);
    end
    `CHK(d, ex)
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    step(1);
    for (i = 0; i < 5; i++) begin
      axr({idxs[i][5:0], 2'b00}, {24'h0, rsts[i]}, RESP_OKAY);
      wr(idxs[i], 8'hA5);
      axr({idxs[i][5:0], 2'b00}, {24'h0, (i == 4) ? 8'h04 : 8'hA5}, RESP_OKAY);
    end
    `CHK(combEnable, 1'b1)
    @(posedge mclk) s_axi_wstrb <= 4'hE;
    axw(8'h3C, 32'h11, RESP_OKAY);
    @(posedge mclk) s_axi_wstrb <= 4'hF;
    axr(8'h3C, 32'hA5, RESP_OKAY);
    axw(8'h04, 32'h11, RESP_SLVERR);
    axw(8'h39, 32'h11, RESP_SLVERR);
    axr(8'h04, 32'h0, RESP_SLVERR);
    for (k = 0; k < 8; k++) begin
      wr(IDX_CHROMA_TWO, {k[1:0], ~k[1:0], k[0], k[2:0]});
      `CHK(blueDiffOut, {8'h5A, k[1:0]})
      `CHK(redDiffOut, {8'hA5, ~k[1:0]})
      `CHK(chromaWide, k[0])
      `CHK(lumaChromaBw, k[2:0])
    end
    wr(IDX_CHROMA_TWO, 8'h0F);
    // Programmed gain ahead of the SECAM searches below
    wr(IDX_GAIN, 8'hA4);
    `CHK(gainManual, 1'b1)
    for (k = 0; k < 4; k++) begin
      wr(IDX_DETECT, {5'h0, k[1], 2'h0});
      wr(IDX_CHROMA_ONE, {4'h5, 2'h0, k[0], k[0]});
      pre = (k == 1 || k == 2);
      `CHK(autoDetectOn, 1'(k != 0))
      `CHK(combEnable, k[0])
      pulse(0);
      step(1);
      `CHK(stdSearching, 1'(k != 0))
      if (k != 0) `CHK(stdCandidate, STD_SECAM_NTSC)
      pulse(1);
      step(1);
      `CHK(stdValid, 1'(k != 0))
      `CHK(filterPresetOn, pre)
      `CHK(sharpPresetOn, 1'(k == 1))
      `CHK(chromaWide, pre ? PRESET_WIDE_SECAM : 1'b1)
      `CHK(lumaChromaBw, pre ? PRESET_LCBW_SECAM : 3'h7)
      if (k != 0) `CHK(stdDetected, STD_SECAM_NTSC)
    end
    wr(IDX_CHROMA_ONE, 8'h42);
    pulse(0);
    step(1);
    `CHK(stdCandidate, STD_PAL_NTSCJ)
    pulse(2);
    step(1);
    `CHK(stdCandidate, STD_SECAM_NTSC)
    wr(IDX_DETECT, 8'h00);
    wr(IDX_CHROMA_ONE, 8'h40);
    `CHK(autoDetectOn, 1'b0)
    `CHK(stdSearching, 1'b0)
    wr(IDX_GAIN, 8'h24);
    `CHK(gainManual, 1'b0)
    `CHK(chromaGainQ, 12'h080)
    @(posedge mclk) agcGainCode <= 7'h7F;
    for (k = 0; k < 3; k++) begin
      wr(IDX_GAIN, 8'h80 | gc[k]);
      `CHK(gainManual, 1'b1)
      `CHK(chromaGainQ, gq[k])
    end
    for (k = 0; k < 4; k++) begin
      @(posedge mclk);
      statusSrcA <= k[0];
      statusSrcB <= ~k[0];
      wr(IDX_MODE_DELAY, {k[0], k[1], 2'h0, k[1], 3'h0});
      `CHK(colourOn, k[0])
      `CHK(status_out_a, k[0] ^ k[1])
      `CHK(status_out_b, ~k[0] ^ k[1])
    end
    @(posedge mclk) colourDetected <= 1'b1;
    wr(IDX_MODE_DELAY, 8'h00);
    `CHK(colourOn, 1'b1)
    for (k = 0; k < 4; k++) begin
      wr(IDX_MODE_DELAY, {2'h0, k[1:0], 4'h0});
      meas(3, 1 + 2 * k);
    end
    for (k = -4; k < 4; k++) begin
      wr(IDX_MODE_DELAY, {5'h0, k[2:0]});
      meas(4, 1 + 2 * (4 + k));
    end
    giveVerdict();
  end
endmodule
`default_nettype wire
